// ---- design/reset_and_standby_sequencer.sv ----
// reset qualification, start-up timing and standby control of the core
// assumes clk is the bus clock and the core drives the request inputs
`timescale 1ns/1ps
`include "rst_seq_defines.svh"
module reset_and_standby_sequencer #(
  parameter int WARMUP_BASE = 16,
  parameter int IO_HALF_PERIOD = 2
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // reset pin, asynchronous, active low
  input wire logic reset_in_n,
  // wake and request pins
  input rst_seq_pkg::wake_pins_t wake_pins_n,
  // core handshakes
  input wire logic sleep_instruction,
  input wire logic global_irq_enable_flag,
  input wire logic extended_mode_req,
  input wire logic refresh_enable_req,
  // internal io access
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // bus and status outputs
  output logic bus_drive_en,
  output logic fetch_start,
  output logic bus_grant,
  output logic stopped_n,
  output logic cpu_run,
  output logic clock_gate_en,
  output logic io_side_clock,
  output logic in_standby,
  output logic refresh_enable,
  output logic extended_mode
);
  import rst_seq_pkg::*;

  seq_state_t state_reg, state_next;
  standby_control_t ctl_reg;
  logic reset_sync;
  logic [3:0] seq_cnt_reg;
  logic [7:0] io_div_reg;
  logic io_running_reg;
  logic fetched_reg;
  logic ief_at_entry_reg;
  logic wake_req_reg;
  logic warm_load;
  logic warm_done;
  logic req;
  logic nmi;
  logic irq_any;
  logic wake_now;
  logic hw_reset;

  // refused at elaboration: the divider count is eight bits wide
  if (IO_HALF_PERIOD < 1 || IO_HALF_PERIOD > 255) begin
    $error("IO_HALF_PERIOD out of range");
  end


  falling_edge_sync #(
    .STAGES(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .reset_in_n(reset_in_n),
    .reset_sync(reset_sync)
  );

  warmup_counter #(
    .BASE(WARMUP_BASE),
    .CW(12)
  ) u_warm (
    .clk(clk),
    .rst(hw_reset),
    .load(warm_load),
    .sel(ctl_reg.warmup_select),
    .done(warm_done)
  );

  assign hw_reset = rst | reset_sync;
  assign req = ~wake_pins_n.bus_request_in;
  assign nmi = ~wake_pins_n.nmi_in;
  assign irq_any = ~&wake_pins_n.maskable_irq_inputs;
  assign wake_now = nmi | (irq_any & ief_at_entry_reg)
    | (req & ~ctl_reg.request_exit_dis);
  assign warm_load = state_reg == ST_STANDBY && state_next == ST_WARMUP;

  // sequencing state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        state_next = ST_STARTUP;
      end
      ST_STARTUP: begin
        if (seq_cnt_reg == 4'(`FETCH_CYC - 1)) begin
          state_next = req ? ST_GRANT : ST_RUN;
        end
      end
      ST_RUN: begin
        if (req) begin
          state_next = ST_GRANT;
        end else if (sleep_instruction) begin
          state_next = ctl_reg.standby_en ? ST_STANDBY : ST_STOPPED;
        end
      end
      ST_GRANT: begin
        if (!req) begin
          state_next = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (wake_now) begin
          state_next = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        if (warm_done) begin
          state_next = wake_req_reg ? ST_GRANT : ST_RUN;
        end
      end
      ST_STOPPED: begin
        if (nmi || (irq_any && global_irq_enable_flag)) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
    if (reset_sync) begin
      state_next = ST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // release counter; stops counting and holds once the io clock is running
  always_ff @(posedge clk) begin
    if (rst || state_reg == ST_RESET) begin
      seq_cnt_reg <= '0;
    end else if (!io_running_reg) begin
      seq_cnt_reg <= seq_cnt_reg + 4'(1);
    end
  end

  // io clock held low through reset, then free-running divider
  always_ff @(posedge clk) begin
    if (rst || state_reg == ST_RESET) begin
      io_running_reg <= 1'b0;
      io_side_clock <= 1'b0;
      io_div_reg <= '0;
    end else if (!io_running_reg) begin
      if (seq_cnt_reg == 4'(`IO_SIDE_CLOCK_CYC - 1)) begin
        io_running_reg <= 1'b1;
        io_side_clock <= 1'b1;
      end
    end else if (io_div_reg == 8'(IO_HALF_PERIOD - 1)) begin
      io_div_reg <= '0;
      io_side_clock <= ~io_side_clock;
    end else begin
      io_div_reg <= io_div_reg + 8'(1);
    end
  end

  // bus and control outputs, registered from the next state; bus drive off in reset, start-up and grant
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_drive_en <= 1'b0;
      fetch_start <= 1'b0;
      bus_grant <= 1'b0;
      stopped_n <= 1'b1;
      cpu_run <= 1'b0;
      clock_gate_en <= 1'b1;
      in_standby <= 1'b0;
      fetched_reg <= 1'b0;
    end else begin
      bus_drive_en <= state_next != ST_RESET && state_next != ST_GRANT
        && state_next != ST_STARTUP;
      fetch_start <= state_next == ST_RUN && !fetched_reg;
      fetched_reg <= state_next == ST_RESET ? 1'b0
        : (fetched_reg | (state_next == ST_RUN));
      bus_grant <= state_next == ST_GRANT;
      stopped_n <= state_next != ST_STOPPED;
      cpu_run <= state_next == ST_RUN;
      clock_gate_en <= state_next != ST_STANDBY
        && state_next != ST_WARMUP;
      in_standby <= state_next == ST_STANDBY;
    end
  end

  // wake bookkeeping
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      ief_at_entry_reg <= 1'b0;
      wake_req_reg <= 1'b0;
    end else if (state_reg == ST_RUN && state_next == ST_STANDBY) begin
      ief_at_entry_reg <= global_irq_enable_flag;
    end else if (warm_load) begin
      // nmi or interrupt outranks a request as the wake cause
      wake_req_reg <= req && !nmi && !(irq_any && ief_at_entry_reg);
    end
  end

  // control registers: take reset values on hw_reset, like the wake bookkeeping and read data
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      ctl_reg <= standby_control_t'(`STANDBY_CONTROL_RESET);
      refresh_enable <= 1'b0;
      extended_mode <= 1'b0;
    end else begin
      if (io_wr && io_addr == `STANDBY_CONTROL_ADDR) begin
        ctl_reg <= standby_control_t'({3'b000, io_wdata[4:0]});
      end
      if (refresh_enable_req) begin
        refresh_enable <= 1'b1;
      end
      if (extended_mode_req) begin
        extended_mode <= 1'b1;
      end
    end
  end

  // read returns the wake cause in the top bit
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      io_rdata <= '0;
    end else if (io_rd && io_addr == `STANDBY_CONTROL_ADDR) begin
      io_rdata <= {wake_req_reg, 2'b00, ctl_reg[4:0]};
    end else begin
      io_rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fetch_delay_a: assert property (
    (state_reg == ST_RESET && !reset_sync && !req) ##1 !reset_sync [*3]
      |=> fetch_start)
    else $error("first fetch not three cycles after release");

  io_side_clock_edge_a: assert property (
    (state_reg == ST_RESET && !reset_sync) ##1 !reset_sync [*8]
      ##1 !reset_sync [*3] |=> $rose(io_side_clock))
    else $error("io clock first rise misplaced");

  io_side_clock_low_a: assert property (
    $rose(io_side_clock) && !$past(io_running_reg)
      |-> $past(io_side_clock, 2) == 1'b0 && $past(io_side_clock, 3) == 1'b0
      && $past(io_side_clock, 4) == 1'b0 && $past(io_side_clock, 5) == 1'b0)
    else $error("io clock not low four cycles before first rise");

  reset_float_a: assert property (
    state_reg == ST_RESET |-> !bus_drive_en && !fetch_start
      && !bus_grant && stopped_n)
    else $error("bus driven or control active during reset");

  grant_at_start_a: assert property (
    state_reg == ST_STARTUP && seq_cnt_reg == 4'(`FETCH_CYC - 1)
      && req && !reset_sync |=> bus_grant && !fetch_start)
    else $error("pending request not granted at start");

  refresh_off_a: assert property (
    $past(reset_sync) |-> !refresh_enable)
    else $error("refresh enabled after reset");

  extended_hold_a: assert property (
    extended_mode && !reset_sync |=> extended_mode)
    else $error("extended mode left without reset");

  request_block_a: assert property (
    state_reg == ST_STANDBY && ctl_reg.request_exit_dis && !nmi
      && !(irq_any && ief_at_entry_reg) && !reset_sync
      |=> state_reg == ST_STANDBY)
    else $error("blocked request ended standby");

  irq_gate_a: assert property (
    state_reg == ST_STANDBY && !ief_at_entry_reg && !nmi && !req
      && !reset_sync |=> state_reg == ST_STANDBY)
    else $error("masked interrupt ended standby");

  nmi_wake_a: assert property (
    state_reg == ST_STANDBY && nmi && !reset_sync
      |=> state_reg == ST_WARMUP ##1 !clock_gate_en)
    else $error("nmi did not start warm-up");

  stop_fallback_a: assert property (
    state_reg == ST_RUN && sleep_instruction && !req
      && !ctl_reg.standby_en && !reset_sync |=> !stopped_n && !cpu_run)
    else $error("sleep without standby did not stop");

  grant_start_c: cover property (
    state_reg == ST_STARTUP ##1 bus_grant);
  standby_wake_c: cover property (
    state_reg == ST_WARMUP ##1 state_reg == ST_RUN);
  stop_c: cover property (
    $fell(stopped_n));
endmodule

// ---- inc/rst_seq_defines.svh ----
// constants for the reset and standby sequencer
// assumes the bus clock is the block clock; times are in bus clock units
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// internal io address and reset value of standby_control
`define STANDBY_CONTROL_ADDR 8'h16
`define STANDBY_CONTROL_RESET 8'h00

// release to first fetch, in half bus clock cycles (3.5 cycles)
`define FETCH_DELAY_HALF 7
// release to first io clock rise, in half bus clock cycles (11.5 cycles)
`define IO_SIDE_CLOCK_EDGE_HALF 23
// least io clock low time before its first rise, in bus clock cycles
`define IO_SIDE_CLOCK_LOW_MIN_CYC 4
// least reset pulse the far side must give, in bus clock cycles
`define RESET_MIN_CYC 10

// whole posedge cycles after the half cycle of falling-edge sampling
`define FETCH_CYC ((`FETCH_DELAY_HALF - 1) / 2)
`define IO_SIDE_CLOCK_CYC ((`IO_SIDE_CLOCK_EDGE_HALF - 1) / 2)

`endif

// ---- inc/rst_seq_pkg.sv ----
// types shared by the reset and standby sequencer files
// assumes rst_seq_defines.svh supplies the numeric constants
package rst_seq_pkg;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_STARTUP = 3'b001,
    ST_RUN     = 3'b010,
    ST_GRANT   = 3'b011,
    ST_STANDBY = 3'b100,
    ST_WARMUP  = 3'b101,
    ST_STOPPED = 3'b110
  } seq_state_t;

  // standby_control layout, msb first
  typedef struct packed {
    logic wake_by_request;
    logic [1:0] rsvd;
    logic standby_en;
    logic request_exit_dis;
    logic [2:0] warmup_select;
  } standby_control_t;

  // wake and request pins, all active low
  typedef struct packed {
    logic bus_request_in;
    logic nmi_in;
    logic [3:0] maskable_irq_inputs;
  } wake_pins_t;

endpackage

// ---- design/falling_edge_sync.sv ----
// falling-edge synchroniser for the asynchronous reset pin
// assumes clk is the bus clock; output is high while reset is asserted
`timescale 1ns/1ps
module falling_edge_sync #(
  parameter int STAGES = 2
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // pin and synchronised level
  input wire logic reset_in_n,
  output logic reset_sync
);
  logic [STAGES-1:0] chain_reg;

  // refused at elaboration: one stage passes metastability straight on
  if (STAGES < 2) begin
    $error("falling_edge_sync needs at least two stages");
  end

  // sampled on the falling edge so posedge logic sees a settled level
  always_ff @(negedge clk) begin
    if (rst) begin
      chain_reg <= '1;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], ~reset_in_n};
    end
  end

  assign reset_sync = chain_reg[STAGES-1];
endmodule

// ---- design/warmup_counter.sv ----
// oscillator warm-up timer for standby exit
// assumes load is a one-cycle pulse; done is a registered pulse
`timescale 1ns/1ps
module warmup_counter #(
  parameter int BASE = 16,
  parameter int CW = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [2:0] sel,
  output logic done
);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;

  // refused at elaboration: the longest wait must fit the counter
  if (BASE < 1 || (BASE << 7) >= (1 << CW)) begin
    $error("warmup_counter BASE does not fit CW");
  end

  // wait grows by powers of two with the select field
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= CW'(BASE << sel) - CW'(1);
      busy_reg <= 1'b1;
      done <= 1'b0;
    end else if (busy_reg && cnt_reg == '0) begin
      busy_reg <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt_reg <= busy_reg ? cnt_reg - CW'(1) : cnt_reg;
      done <= 1'b0;
    end
  end
endmodule

// ---- test/far_side_model.sv ----
// far side: external reset source and bus requesting master
// assumes bench commands change on falling edges; pins move after rise
`timescale 1ns/1ps
module far_side_model #(
  parameter int HOLD = 10
) (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic do_reset,
  input wire logic req,
  // pins toward the block
  output logic reset_in_n,
  output logic bus_request_n
);
  int cnt = 0;
  initial reset_in_n = 1'b1;
  initial bus_request_n = 1'b1;
  // a clocked source: pins change just after the rising edge
  always @(posedge clk) begin
    bus_request_n <= #1 ~req;
    if (do_reset && cnt == 0) begin
      cnt <= HOLD;
      reset_in_n <= #1 1'b0;
    end else if (cnt == 1) begin
      cnt <= 0;
      reset_in_n <= #1 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ---- test/tb_reset_and_standby_sequencer.sv ----
// self-checking bench for the reset and standby sequencer
// assumes a 200 MHz bus clock and the far side model beside it
`timescale 1ns/1ps
`include "rst_seq_defines.svh"
module tb_reset_and_standby_sequencer;
  import rst_seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic do_reset = 1'b0;
  logic req = 1'b0;
  logic nmi_n = 1'b1;
  logic [3:0] irq_n = 4'hF;
  logic sleep = 1'b0;
  logic flag = 1'b0;
  logic ext_req = 1'b0;
  logic rfsh_req = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_rdata;
  logic bus_drive_en, fetch_start, bus_grant, stopped_n, cpu_run;
  logic clock_gate_en, io_side_clock, in_standby, refresh_enable;
  logic extended_mode, reset_in_n, bus_request_n;
  wake_pins_t wake;
  int errors = 0;
  int total_checks = 0;
  int n;

  assign wake = {bus_request_n, nmi_n, irq_n};
  always #2.5 clk = ~clk;

  far_side_model i_far (.clk(clk), .do_reset(do_reset), .req(req),
    .reset_in_n(reset_in_n), .bus_request_n(bus_request_n));

  reset_and_standby_sequencer #(.WARMUP_BASE(2)) i_dut (
    .clk(clk), .rst(rst), .reset_in_n(reset_in_n), .wake_pins_n(wake),
    .sleep_instruction(sleep), .global_irq_enable_flag(flag),
    .extended_mode_req(ext_req), .refresh_enable_req(rfsh_req),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .bus_drive_en(bus_drive_en),
    .fetch_start(fetch_start), .bus_grant(bus_grant),
    .stopped_n(stopped_n), .cpu_run(cpu_run),
    .clock_gate_en(clock_gate_en), .io_side_clock(io_side_clock),
    .in_standby(in_standby), .refresh_enable(refresh_enable),
    .extended_mode(extended_mode));

  task chk(input logic [31:0] got, input logic [31:0] lo,
           input logic [31:0] hi);
    total_checks++;
    // xor with itself exposes unknown bits
    if ((got ^ got) !== 32'h0 || got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h..%h",
               $time, got, lo, hi);
    end
  endtask

  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    chk(io_rdata, exp, exp);
    // idle cycle so a following read does not reassign the strobe
    @(negedge clk);
  endtask

  task wait_cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task do_sleep;
    sleep = 1'b1;
    @(negedge clk);
    sleep = 1'b0;
    wait_cyc(2);
  endtask

  task do_nmi;
    nmi_n = 1'b0;
    @(negedge clk);
    nmi_n = 1'b1;
  endtask

  task tdone(input string name);
    $display("test %s finished, checks %0d", name, total_checks);
  endtask

  // pin reset through the far side, then time the start-up
  task pin_reset(input logic with_req);
    int f;
    int nf;
    f = 0;
    nf = 0;
    n = 0;
    req = with_req;
    do_reset = 1'b1;
    @(negedge clk);
    do_reset = 1'b0;
    @(posedge reset_in_n);
    chk({bus_drive_en, cpu_run, io_side_clock}, 0, 0);
    chk({refresh_enable, extended_mode}, 0, 0);
    while (n < 40 && io_side_clock !== 1'b1) begin
      @(negedge clk);
      n++;
      if (fetch_start === 1'b1) nf++;
      if (f == 0 && (fetch_start === 1'b1 || bus_grant === 1'b1)) f = n;
    end
    chk(f, `FETCH_CYC + 3, `FETCH_CYC + 3);
    chk(n - f, `IO_SIDE_CLOCK_CYC - `FETCH_CYC, `IO_SIDE_CLOCK_CYC - `FETCH_CYC);
    chk(nf, !with_req, !with_req);
    chk({bus_grant, bus_drive_en}, {with_req, !with_req},
        {with_req, !with_req});
  endtask

  // sleep, present wake sources, see whether standby ends
  task sw(input logic [3:0] irq, input logic r, input logic ex);
    do_sleep();
    chk(in_standby, 1, 1);
    irq_n = irq;
    req = r;
    wait_cyc(12);
    chk(in_standby, !ex, !ex);
    irq_n = 4'hF;
    req = 1'b0;
    do_nmi();
    wait_cyc(12);
    chk(cpu_run, 1, 1);
  endtask

  initial begin
    #50000;
    errors++;
    conclude();
  end

  initial begin
    wait_cyc(2);
    rst = 1'b0;
    wait_cyc(3);
    pin_reset(1'b0);
    tdone("startup");
    rd(8'h16, 8'h00);
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h1F);
    rd(8'h15, 8'h00);
    wr(8'h15, 8'h07);
    rd(8'h16, 8'h1F);
    tdone("registers");
    rfsh_req = 1'b1;
    ext_req = 1'b1;
    @(negedge clk);
    rfsh_req = 1'b0;
    ext_req = 1'b0;
    wait_cyc(20);
    chk({refresh_enable, extended_mode}, 3, 3);
    tdone("modes");
    wr(8'h16, 8'h00);
    do_sleep();
    chk({stopped_n, cpu_run, in_standby}, 0, 0);
    do_nmi();
    wait_cyc(4);
    chk({stopped_n, cpu_run}, 3, 3);
    tdone("stop");
    // every warm-up code, woken by nmi
    for (int s = 0; s < 8; s++) begin
      wr(8'h16, 8'h10 | s[7:0]);
      do_sleep();
      chk({in_standby, clock_gate_en}, 2, 2);
      do_nmi();
      n = 0;
      while (n < 1000 && cpu_run !== 1'b1) begin
        @(negedge clk);
        n++;
      end
      chk(n, 2 << s, (2 << s) + 4);
    end
    tdone("warmup");
    wr(8'h16, 8'h10);
    flag = 1'b0;
    sw(4'hE, 1'b0, 1'b0);
    flag = 1'b1;
    sw(4'hE, 1'b0, 1'b1);
    sw(4'hF, 1'b1, 1'b1);
    rd(8'h16, 8'h90);
    wr(8'h16, 8'h18);
    sw(4'hF, 1'b1, 1'b0);
    tdone("wake");
    pin_reset(1'b1);
    req = 1'b0;
    wait_cyc(6);
    chk({cpu_run, bus_grant}, 2, 2);
    tdone("request at reset");
    conclude();
  end
endmodule
